/* pkg/dmbag_pkg.sv */
package dmbag_pkg;

  // ----------------------------------------------------------------------
  // address shape
  // ----------------------------------------------------------------------
  localparam int BANK_W = 4;
  localparam int LOC_W  = 8;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------------
  // bank numbers
  // ----------------------------------------------------------------------
  localparam logic [3:0] BANK_0  = 4'h0;
  localparam logic [3:0] BANK_1  = 4'h1;
  localparam logic [3:0] BANK_2  = 4'h2;
  localparam logic [3:0] BANK_3  = 4'h3;
  localparam logic [3:0] BANK_15 = 4'hF;

  // ----------------------------------------------------------------------
  // map landmarks
  // ----------------------------------------------------------------------
  localparam logic [7:0] LOC_HALF      = 8'h80;
  localparam logic [7:0] DISP_FIRST    = 8'hE0;
  localparam logic [7:0] WREG_LAST     = 8'h07;
  localparam logic [7:0] SEQBUF_FIRST  = 8'hC0;
  localparam logic [7:0] SEQBUF_LAST   = 8'hC3;
  localparam logic [5:0] PBIT_TOP      = 6'h3F;
  localparam logic [7:0] FBIT_IRQ_BASE = 8'hB0;
  localparam logic [7:0] FBIT_PORT_BASE = 8'hF0;
  localparam logic       BWS_RESET     = 1'b0;

  // ----------------------------------------------------------------------
  // access modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    DMBAG_DIRECT   = 4'h0,
    DMBAG_IND_MAIN = 4'h1,
    DMBAG_IND_SEC  = 4'h2,
    DMBAG_IND_MIX  = 4'h3,
    DMBAG_FBIT     = 4'h4,
    DMBAG_PBIT     = 4'h5,
    DMBAG_HBIT     = 4'h6,
    DMBAG_STACK    = 4'h7
  } dmbag_mode_e;

endpackage : dmbag_pkg

/* src/dmbag_addr_gen.sv */
// Summary of operation
// - switch clear: bank0 low, bank15 high halves
// - switch set: bank from register upper nibble
// - banks 0,1,15 always; 2,3 large only
// - RAM banks hold 256 nibbles each
// - bank1 top 32 nibbles feed display
// - eight working nibbles at bank0 from 00H
// - bank15 upper peripherals except C0H-C3H buffer RAM, lower no RAM
// - direct operand: switch clear splits by offset
// - main pair indirect uses bank controls
// - alternate pairs always use bank 0
// - fixed-bank bits always in bank 15
// - pointer bits at FC0H-FFFH from operand, L
// - high pointer nibble plus operand nibble
// - stack always bank 0 at pointer
// - direct peripheral needs switch clear or bank15
// - indirect peripheral needs switch set, bank15
// - switch reloaded from reset, interrupt vectors
`timescale 1ns/1ns
`default_nettype none
module dmbag_addr_gen
  import dmbag_pkg::*;
#(
  parameter bit LARGE_RAM = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        vec_load,
  input  wire logic        vec_switch,
  input  wire logic        bank_reg_we,
  input  wire logic [7:0]  bank_reg_wdata,
  input  wire logic        req,
  input  wire logic [3:0]  mode,
  input  wire logic        byte_acc,
  input  wire logic [7:0]  operand,
  input  wire logic [7:0]  pointer_pair_main,
  input  wire logic [7:0]  pointer_pair_second,
  input  wire logic [7:0]  pointer_pair_mixed,
  input  wire logic [7:0]  stack_ptr,
  output logic             bank_window_switch,
  output logic [7:0]       bank_register,
  output logic             addr_valid,
  output logic [11:0]      addr,
  output logic [1:0]       bit_sel,
  output logic             is_ram,
  output logic             is_periph,
  output logic             is_display,
  output logic             is_wreg,
  output logic             access_err
);

  // ----------------------------------------------------------------------
  // bank controls
  // ----------------------------------------------------------------------
  logic [3:0] bank_number_field;
  assign bank_number_field = bank_register[7:4];

  // reset and every vector fetch carry their own switch value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_window_switch <= BWS_RESET;
    end else if (vec_load) begin
      bank_window_switch <= vec_switch;
    end
  end

  // only the upper nibble matters here, the low nibble is carried along
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_register <= 8'h00;
    end else if (bank_reg_we) begin
      bank_register <= bank_reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  // the high-pointer bit form counts as direct for the peripheral rule
  logic mode_direct;
  logic mode_main;
  logic mode_hbit;

  assign mode_main   = (dmbag_mode_e'(mode) == DMBAG_IND_MAIN);
  assign mode_hbit   = (dmbag_mode_e'(mode) == DMBAG_HBIT);
  assign mode_direct = (dmbag_mode_e'(mode) == DMBAG_DIRECT) || mode_hbit;

  // ----------------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------------
  logic [3:0] next_bank;
  logic [7:0] next_loc;
  logic [1:0] next_bit;
  logic       next_indirect_main;
  logic [3:0] ctl_bank;
  logic [7:0] ctl_loc;

  // the split reads its own copy of the location, so the bank choice
  // never loops back through the location mux
  always_comb begin
    if (mode_main) begin
      ctl_loc = pointer_pair_main;
    end else if (mode_hbit) begin
      ctl_loc = {pointer_pair_main[7:4], operand[3:0]};
    end else begin
      ctl_loc = operand;
    end
  end

  // switch clear: bank 0 below the split, bank 15 at and above
  always_comb begin
    if (!bank_window_switch) begin
      ctl_bank = (ctl_loc < LOC_HALF) ? BANK_0 : BANK_15;
    end else begin
      ctl_bank = bank_number_field;
    end
  end

  always_comb begin
    next_bank          = BANK_0;
    next_loc           = operand;
    next_bit           = operand[1:0];
    next_indirect_main = 1'b0;
    case (dmbag_mode_e'(mode))
      DMBAG_DIRECT: begin
        next_loc = operand;
        next_bank = ctl_bank;
      end
      DMBAG_IND_MAIN: begin
        next_loc = pointer_pair_main;
        next_bank = ctl_bank;
        next_indirect_main = 1'b1;
      end
      DMBAG_IND_SEC: begin
        next_loc = pointer_pair_second;
        next_bank = BANK_0;
      end
      DMBAG_IND_MIX: begin
        next_loc = pointer_pair_mixed;
        next_bank = BANK_0;
      end
      DMBAG_FBIT: begin
        // operand[4] picks the port group over the flag group
        next_loc = {(operand[4] ? FBIT_PORT_BASE[7:4] : FBIT_IRQ_BASE[7:4]),
                    operand[3:0]};
        next_bank = BANK_15;
        next_bit = operand[1:0];
      end
      DMBAG_PBIT: begin
        // operand upper bits set the 4-nibble group, L picks within it
        next_loc = {PBIT_TOP[5:4], operand[5:2],
                    pointer_pair_main[3:2]};
        next_bank = BANK_15;
        next_bit = pointer_pair_main[1:0];
      end
      DMBAG_HBIT: begin
        next_loc = {pointer_pair_main[7:4], operand[3:0]};
        next_bank = ctl_bank;
        next_bit = operand[1:0];
      end
      DMBAG_STACK: begin
        next_loc = stack_ptr;
        next_bank = BANK_0;
      end
      default: begin
        next_loc = operand;
        next_bank = BANK_0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // map decode
  // ----------------------------------------------------------------------
  logic bank_ram;
  logic periph;
  logic seqbuf;
  logic next_err;

  always_comb begin
    // large variant only adds banks 2 and 3
    if (next_bank == BANK_0 || next_bank == BANK_1) begin
      bank_ram = 1'b1;
    end else if (next_bank == BANK_2 || next_bank == BANK_3) begin
      bank_ram = LARGE_RAM;
    end else begin
      bank_ram = 1'b0;
    end
  end

  // the sequential buffer is the only RAM above the bank 15 split
  assign periph = (next_bank == BANK_15) && (next_loc >= LOC_HALF);
  assign seqbuf = periph && (next_loc >= SEQBUF_FIRST)
                  && (next_loc <= SEQBUF_LAST);

  always_comb begin
    next_err = 1'b0;
    if (next_bank == BANK_15 && next_loc < LOC_HALF) begin
      next_err = 1'b1;
    end else if (!bank_ram && next_bank != BANK_15) begin
      next_err = 1'b1;
    end else if (periph && mode_direct && bank_window_switch
                 && bank_number_field != BANK_15) begin
      next_err = 1'b1;
    end else if (periph && next_indirect_main
                 && (!bank_window_switch
                     || bank_number_field != BANK_15)) begin
      next_err = 1'b1;
    end else if (byte_acc && next_loc[0]) begin
      // odd byte address flagged, not silently realigned
      next_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // registered address
  // ----------------------------------------------------------------------
  logic [11:0] next_addr;
  assign next_addr = {next_bank, next_loc};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_valid <= 1'b0;
    end else begin
      addr_valid <= req;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr <= 12'h000;
    end else begin
      addr <= next_addr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_sel <= 2'h0;
    end else begin
      bit_sel <= next_bit;
    end
  end

  // ----------------------------------------------------------------------
  // registered map flags
  // ----------------------------------------------------------------------
  // a flag only rises for a cycle that carried a request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_ram <= 1'b0;
    end else begin
      is_ram <= req && ((bank_ram && !next_err) || seqbuf);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_periph <= 1'b0;
    end else begin
      is_periph <= req && periph && !seqbuf && !next_err;
    end
  end

  // display nibbles stay plain RAM, so no refusal is tied to them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_display <= 1'b0;
    end else begin
      is_display <= req && next_bank == BANK_1
                    && next_loc >= DISP_FIRST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_wreg <= 1'b0;
    end else begin
      is_wreg <= req && next_bank == BANK_0
                 && next_loc <= WREG_LAST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      access_err <= 1'b0;
    end else begin
      access_err <= req && next_err;
    end
  end

endmodule : dmbag_addr_gen
`default_nettype wire

/* testbench/dmbag_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dmbag_cpu_model (
  input  wire logic       clk,
  output var  logic       req,
  output var  logic [3:0] mode,
  output var  logic       byte_acc,
  output var  logic [7:0] operand,
  output var  logic [7:0] ptr,
  output var  logic       we,
  output var  logic [7:0] wdata,
  output var  logic       vld,
  output var  logic       vsw
);
  // ----
  // cpu side
  // ----
  initial begin
    {req, mode, byte_acc, operand, ptr, we, wdata, vld, vsw} = '0;
  end
  // callers pass even byte locations unless a refusal is wanted
  task go(input logic [3:0] m, input logic b, input logic [7:0] o, p);
    @(posedge clk);
    #1;
    {req, mode, byte_acc, operand, ptr} = {1'b1, m, b, o, p};
    @(posedge clk);
    #1;
    req = 1'b0;
    // idle lines flip so stale values never look valid
    operand = ~o;
    ptr = ~p;
  endtask : go
  task set(input logic l, s, w, input logic [7:0] d);
    @(posedge clk);
    #1;
    {vld, vsw, we, wdata} = {l, s, w, d};
    @(posedge clk);
    #1;
    {vld, we} = 2'b00;
  endtask : set
endmodule : dmbag_cpu_model
`default_nettype wire

/* testbench/dmbag_addr_gen_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module dmbag_addr_gen_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req,
  input wire logic [3:0]  mode,
  input wire logic [7:0]  operand,
  input wire logic [7:0]  pointer_pair_main,
  input wire logic [7:0]  pointer_pair_second,
  input wire logic [7:0]  stack_ptr,
  input wire logic        bank_window_switch,
  input wire logic [7:0]  bank_register,
  input wire logic        addr_valid,
  input wire logic [11:0] addr,
  input wire logic [1:0]  bit_sel,
  input wire logic        access_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_valid_follows: assert property (addr_valid == $past(req))
    else $error("valid not one cycle after request");
  a_stack_bank: assert property (req && mode == 4'h7 |=>
    addr == {4'h0, $past(stack_ptr)}) else $error("stack address");
  a_alt_bank: assert property (req && mode == 4'h2 |=>
    addr == {4'h0, $past(pointer_pair_second)}) else $error("alt pair");
  a_fbit_bank: assert property (req && mode == 4'h4 |=> addr[11:4] ==
    {4'hF, ($past(operand[4]) ? 4'hF : 4'hB)}) else $error("fixed bit");
  a_pbit_form: assert property (req && mode == 4'h5 |=> addr == {6'h3F,
    $past(operand[5:2]), $past(pointer_pair_main[3:2])} &&
    bit_sel == $past(pointer_pair_main[1:0])) else $error("ptr bit");
  a_direct_split: assert property (req && mode == 4'h0 && !bank_window_switch
    |=> addr == {($past(operand[7]) ? 4'hF : 4'h0), $past(operand)})
    else $error("direct split");
  a_window_bank: assert property (req && bank_window_switch && mode < 4'h2
    |=> addr[11:8] == $past(bank_register[7:4]))
    else $error("window bank");
  a_hbit_upper: assert property (req && mode == 4'h6 |=> addr[7:4] ==
    $past(pointer_pair_main[7:4])) else $error("high pointer bit");
  a_b15_low: assert property (req && mode == 4'h0 && bank_window_switch &&
    bank_register[7:4] == 4'hF && !operand[7] |=> access_err)
    else $error("bank 15 low half");
  c_stack: cover property (req && mode == 4'h7);
  c_window: cover property (req && bank_window_switch);
  c_err: cover property (access_err);
endmodule : dmbag_addr_gen_chk
bind dmbag_addr_gen dmbag_addr_gen_chk u_dmbag_addr_gen_chk (.clk, .rst,
  .req, .mode, .operand, .pointer_pair_main, .pointer_pair_second,
  .stack_ptr, .bank_window_switch, .bank_register, .addr_valid, .addr,
  .bit_sel, .access_err);
`default_nettype wire

/* testbench/data_memory_bank_address_gen_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module data_memory_bank_address_gen_tb_top;
  logic clk, rst, req, ba, we, vld, vsw, bws, av, ram, per, dsp, wr, err;
  logic [3:0] mode;
  logic [7:0] op, ptr, wd, br;
  logic [11:0] addr;
  logic [1:0] bs;
  int error_cnt, num_checks;
  dmbag_cpu_model u_dmbag_cpu_model (.clk, .req, .mode, .byte_acc(ba),
    .operand(op), .ptr, .we, .wdata(wd), .vld, .vsw);
  dmbag_addr_gen u_dmbag_addr_gen (.clk, .rst, .vec_load(vld),
    .vec_switch(vsw), .bank_reg_we(we), .bank_reg_wdata(wd), .req, .mode,
    .byte_acc(ba), .operand(op), .pointer_pair_main(ptr),
    .pointer_pair_second(ptr), .pointer_pair_mixed({ptr[3:0], ptr[7:4]}),
    .stack_ptr(~ptr), .bank_window_switch(bws), .bank_register(br),
    .addr_valid(av), .addr, .bit_sel(bs), .is_ram(ram), .is_periph(per),
    .is_display(dsp), .is_wreg(wr), .access_err(err));
  wire logic [5:0] fl = {av, ram, per, dsp, wr, err};
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input string n, input logic [23:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task t_clear;
    u_dmbag_cpu_model.go(4'h0, 1'b0, 8'h7F, 8'h00);
    chk("lo", {12'h07F, 6'h30}, {addr, fl});
    u_dmbag_cpu_model.go(4'h0, 1'b0, 8'h80, 8'h00);
    chk("hi", {12'hF80, 6'h28}, {addr, fl});
    u_dmbag_cpu_model.go(4'h1, 1'b0, 8'h00, 8'h85);
    chk("main", {12'hF85, 1'b1}, {addr, err});
    $display("t_clear done");
  endtask : t_clear
  task t_window;
    u_dmbag_cpu_model.set(1'b1, 1'b1, 1'b0, 8'h00);
    chk("sw", 1'b1, bws);
    u_dmbag_cpu_model.set(1'b0, 1'b0, 1'b1, 8'h1A);
    chk("br", 8'h1A, br);
    u_dmbag_cpu_model.go(4'h1, 1'b0, 8'h00, 8'hE4);
    chk("disp", {12'h1E4, 6'h34}, {addr, fl});
    u_dmbag_cpu_model.go(4'h6, 1'b0, 8'h07, 8'hA3);
    chk("hbit", 8'h1A, addr[11:4]);
    u_dmbag_cpu_model.set(1'b0, 1'b0, 1'b1, 8'h20);
    u_dmbag_cpu_model.go(4'h0, 1'b0, 8'h10, 8'h00);
    chk("bank2", 1'b1, err);
    u_dmbag_cpu_model.set(1'b0, 1'b0, 1'b1, 8'hF0);
    u_dmbag_cpu_model.go(4'h0, 1'b0, 8'h85, 8'h00);
    chk("per", {12'hF85, 6'h28}, {addr, fl});
    u_dmbag_cpu_model.go(4'h0, 1'b0, 8'hC1, 8'h00);
    chk("seq", {12'hFC1, 6'h30}, {addr, fl});
    u_dmbag_cpu_model.go(4'h0, 1'b0, 8'h20, 8'h00);
    chk("b15lo", 1'b1, err);
    u_dmbag_cpu_model.go(4'h1, 1'b1, 8'h00, 8'h86);
    chk("even", {12'hF86, 1'b0}, {addr, err});
    u_dmbag_cpu_model.go(4'h1, 1'b1, 8'h00, 8'h87);
    chk("odd", 1'b1, err);
    $display("t_window done");
  endtask : t_window
  task t_fixed;
    u_dmbag_cpu_model.go(4'h7, 1'b0, 8'h00, 8'h65);
    chk("stack", 12'h09A, addr);
    u_dmbag_cpu_model.go(4'h3, 1'b0, 8'h00, 8'h21);
    chk("mix", 12'h012, addr);
    u_dmbag_cpu_model.go(4'h2, 1'b0, 8'h00, 8'h05);
    chk("wreg", {12'h005, 6'h32}, {addr, fl});
    u_dmbag_cpu_model.go(4'h4, 1'b0, 8'h15, 8'h00);
    chk("port", {12'hFF5, 2'h1}, {addr, bs});
    u_dmbag_cpu_model.go(4'h4, 1'b0, 8'h03, 8'h00);
    chk("flag", 12'hFB3, addr);
    u_dmbag_cpu_model.go(4'h5, 1'b0, 8'h08, 8'h0E);
    chk("pbit", {12'hFCB, 2'h2}, {addr, bs});
    $display("t_fixed done");
  endtask : t_fixed
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("reset", 22'h0, {bws, br, av, addr});
    t_clear();
    t_window();
    t_fixed();
    stop_test();
  end
  // watchdog for a hung run
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule : data_memory_bank_address_gen_tb_top
`default_nettype wire
